// ==== inc/cwm_pkg.sv ====
// Constants, register map and mode codes of the waveform generator.
// Assumes an 8-bit register port with a 4-bit byte address.
package cwm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int DB_W   = 6;
    localparam int NOUT   = 4;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_CONTROL_0 = 4'h0;
    localparam logic [3:0] OFS_CONTROL_1 = 4'h1;
    localparam logic [3:0] OFS_STEER     = 4'h2;
    localparam logic [3:0] OFS_DB_RISE   = 4'h3;
    localparam logic [3:0] OFS_DB_FALL   = 4'h4;
    localparam logic [3:0] OFS_DB_EN     = 4'h5;
    localparam logic [3:0] OFS_SHUTDOWN  = 4'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int F_ENABLE    = 7;
    localparam int F_MODE_LSB  = 0;
    localparam int F_POL_LSB   = 0;
    localparam int F_LIVE_LSB  = 4;
    localparam int F_STR_LSB   = 0;
    localparam int F_OVR_LSB   = 4;
    localparam int F_RISE_EN   = 0;
    localparam int F_FALL_EN   = 1;
    localparam int F_PIN_SRC   = 0;
    localparam int F_AUTO_RST  = 1;
    localparam int F_SHUT      = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic       RST_ENABLE = 1'b0;
    localparam logic [2:0] RST_MODE   = 3'h0;
    localparam logic [3:0] RST_POL    = 4'h0;
    localparam logic [3:0] RST_STR    = 4'h0;
    localparam logic [3:0] RST_OVR    = 4'h0;
    localparam logic [5:0] RST_DB     = 6'h00;
    localparam logic [7:0] RD_ZERO    = 8'h00;

    // ------------------------------------------------------------
    // Operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_STEER_ASYNC = 3'b000,
        MODE_STEER_SYNC  = 3'b001,
        MODE_FB_FORWARD  = 3'b010,
        MODE_FB_REVERSE  = 3'b011,
        MODE_HALF_BRIDGE = 3'b100,
        MODE_PUSH_PULL   = 3'b101,
        MODE_UNDEF_6     = 3'b110,
        MODE_UNDEF_7     = 3'b111
    } cwm_mode_t;

    localparam logic [1:0] FB_MODE_HI = 2'b01;

endpackage

// ==== inc/cwm_db_if.sv ====
// Link between the generator core and one dead-band timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface cwm_db_if;
    logic       in_level;
    logic [5:0] count;
    logic       enable;
    logic       out_level;

    modport ctrl  (output in_level, output count, output enable,
                   input  out_level);
    modport timer (input  in_level, input  count, input  enable,
                   output out_level);
endinterface

// ==== verilog/cwm_deadband.sv ====
// Dead-band timer: delays the rising edge of its input, passes falls.
// Assumes a synchronous input and one clock.
`timescale 1ns/1ps
module cwm_deadband (
    // Clock and reset
    input  wire logic CLOCK,
    input  wire logic RST,
    // Core side
    cwm_db_if.timer   db
);

    logic [5:0] cnt;
    logic       level;

    // ------------------------------------------------------------
    // Delay counter
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST || !db.in_level) begin
            cnt   <= 6'h00;
            level <= 1'b0;
        end else if (!level) begin
            // A fall cuts any pending rise, so no pulse leaks through
            if (!db.enable || cnt == db.count) begin
                level <= 1'b1;
            end else begin
                cnt <= cnt + 6'h01;
            end
        end
    end

    assign db.out_level = level;

endmodule

// ==== verilog/cwm_outstage.sv ====
// One output driver stage: polarity, override and the output flop.
// Assumes logical active-high levels from the core.
`timescale 1ns/1ps
module cwm_outstage (
    // Clock and reset
    input  wire logic CLOCK,
    input  wire logic RST,
    // Levels
    input  wire logic active,
    input  wire logic force_ovr,
    input  wire logic ovr_level,
    input  wire logic polarity,
    // Pin
    output logic      pin
);

    // ------------------------------------------------------------
    // Output flop
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin <= 1'b1;
        end else if (force_ovr) begin
            pin <= ovr_level;
        end else begin
            pin <= polarity ? active : ~active;
        end
    end

endmodule

// ==== verilog/cwm_top.sv ====
// Complementary waveform generator: one data input, four driver outputs.
// Assumes synchronous DATA_IN and FAULT_IN and a one-cycle register port.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
module cwm_top (
    // Clock and reset
    input  wire logic       CLOCK,
    input  wire logic       RST,
    // Register port
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    // Waveform input and fault
    input  wire logic       DATA_IN,
    input  wire logic       FAULT_IN,
    // Driver outputs
    output logic            OUT_A,
    output logic            OUT_B,
    output logic            OUT_C,
    output logic            OUT_D
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic                enable;
    cwm_pkg::cwm_mode_t  mode;
    logic [3:0]          polarity_per_output;
    logic [3:0]          steer;
    logic [3:0]          steer_sync;
    logic [3:0]          steer_eff;
    logic [3:0]          ovr;
    logic [5:0]          db_rise;
    logic [5:0]          db_fall;
    logic                db_rise_en;
    logic                db_fall_en;
    logic                pin_src_en;
    logic                auto_restart;
    logic                shut;
    logic                next_shut;
    logic                fault_evt;
    logic                data_q;
    logic                data_rise;
    logic                fb_reverse;
    logic                pp_next_b;
    logic                run;
    logic [3:0]          active;
    logic [3:0]          force_ovr;
    logic [3:0]          out_pins;
    logic                wr_ctl0;
    logic                wr_ctl1;
    logic                wr_steer;
    logic                wr_shut;
    logic                wr_db;

    cwm_db_if            rise_if ();
    cwm_db_if            fall_if ();

    assign wr_ctl0  = WR && ADDR == cwm_pkg::OFS_CONTROL_0;
    assign wr_ctl1  = WR && ADDR == cwm_pkg::OFS_CONTROL_1;
    assign wr_steer = WR && ADDR == cwm_pkg::OFS_STEER;
    assign wr_shut  = WR && ADDR == cwm_pkg::OFS_SHUTDOWN;
    assign wr_db    = WR && ADDR == cwm_pkg::OFS_DB_EN;

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            enable <= cwm_pkg::RST_ENABLE;
            mode   <= cwm_pkg::cwm_mode_t'(cwm_pkg::RST_MODE);
        end else if (wr_ctl0) begin
            // Any write is taken; a bit 0 flip in full-bridge is legal live
            enable <= WDATA[cwm_pkg::F_ENABLE];
            mode   <= cwm_pkg::cwm_mode_t'(WDATA[cwm_pkg::F_MODE_LSB +: 3]);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            polarity_per_output <= cwm_pkg::RST_POL;
        end else if (wr_ctl1) begin
            polarity_per_output <= WDATA[cwm_pkg::F_POL_LSB +: 4];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            steer <= cwm_pkg::RST_STR;
            ovr   <= cwm_pkg::RST_OVR;
        end else if (wr_steer) begin
            steer <= WDATA[cwm_pkg::F_STR_LSB +: 4];
            ovr   <= WDATA[cwm_pkg::F_OVR_LSB +: 4];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            db_rise <= cwm_pkg::RST_DB;
        end else if (WR && ADDR == cwm_pkg::OFS_DB_RISE) begin
            db_rise <= WDATA[5:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            db_fall <= cwm_pkg::RST_DB;
        end else if (WR && ADDR == cwm_pkg::OFS_DB_FALL) begin
            db_fall <= WDATA[5:0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            db_rise_en <= 1'b0;
            db_fall_en <= 1'b0;
        end else if (wr_db) begin
            db_rise_en <= WDATA[cwm_pkg::F_RISE_EN];
            db_fall_en <= WDATA[cwm_pkg::F_FALL_EN];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            pin_src_en   <= 1'b0;
            auto_restart <= 1'b0;
        end else if (wr_shut) begin
            pin_src_en   <= WDATA[cwm_pkg::F_PIN_SRC];
            auto_restart <= WDATA[cwm_pkg::F_AUTO_RST];
        end
    end

    // ------------------------------------------------------------
    // Auto-shutdown
    // ------------------------------------------------------------
    // A fault in the clearing cycle keeps the state set
    assign fault_evt = pin_src_en && FAULT_IN;

    always_comb begin
        if (fault_evt) begin
            next_shut = 1'b1;
        end else if (wr_shut) begin
            next_shut = WDATA[cwm_pkg::F_SHUT];
        end else if (auto_restart) begin
            next_shut = 1'b0;
        end else begin
            next_shut = shut;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            shut <= 1'b0;
        end else begin
            shut <= next_shut;
        end
    end

    // ------------------------------------------------------------
    // Input edge and sequencing state
    // ------------------------------------------------------------
    assign run       = enable && !shut;
    assign data_rise = DATA_IN && !data_q;

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            data_q <= 1'b0;
        end else begin
            data_q <= DATA_IN;
        end
    end

    // Direction is resampled on a data rise or while disabled, to avoid runt pulses
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            fb_reverse <= 1'b0;
        end else if (!enable || data_rise) begin
            fb_reverse <= mode[0];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            steer_sync <= cwm_pkg::RST_STR;
        end else if (!enable || data_rise) begin
            steer_sync <= steer;
        end
    end

    assign steer_eff = (mode == cwm_pkg::MODE_STEER_SYNC) ? steer_sync
                                                          : steer;

    // Flips at pulse end: no pulse starts on the old pin
    always_ff @(posedge CLOCK) begin
        if (RST || !run) begin
            pp_next_b <= 1'b0;
        end else if (data_q && !DATA_IN) begin
            pp_next_b <= ~pp_next_b;
        end
    end

    // ------------------------------------------------------------
    // Dead-band timers
    // ------------------------------------------------------------
    assign rise_if.in_level = run && DATA_IN;
    assign rise_if.count    = db_rise;
    assign rise_if.enable   = db_rise_en;
    assign fall_if.in_level = run && !DATA_IN;
    assign fall_if.count    = db_fall;
    assign fall_if.enable   = db_fall_en;

    cwm_deadband u_db_rise (
        .CLOCK (CLOCK),
        .RST   (RST),
        .db    (rise_if.timer)
    );

    cwm_deadband u_db_fall (
        .CLOCK (CLOCK),
        .RST   (RST),
        .db    (fall_if.timer)
    );

    // ------------------------------------------------------------
    // Mode decode to logical levels (bit 0 is A)
    // ------------------------------------------------------------
    always_comb begin
        active    = 4'h0;
        force_ovr = 4'h0;
        if (enable) begin
            case (mode)
                cwm_pkg::MODE_STEER_ASYNC,
                cwm_pkg::MODE_STEER_SYNC: begin
                    // Unsteered pins hold their override level
                    active    = {4{DATA_IN}};
                    force_ovr = ~steer_eff | (shut ? steer_eff : 4'h0);
                end
                cwm_pkg::MODE_FB_FORWARD,
                cwm_pkg::MODE_FB_REVERSE: begin
                    if (!fb_reverse) begin
                        active = {rise_if.out_level, 2'b00, 1'b1};
                    end else begin
                        active = {1'b0, 1'b1, rise_if.out_level, 1'b0};
                    end
                    force_ovr = {4{shut}};
                end
                cwm_pkg::MODE_HALF_BRIDGE: begin
                    active = {fall_if.out_level, rise_if.out_level,
                              fall_if.out_level, rise_if.out_level};
                    force_ovr = {4{shut}};
                end
                cwm_pkg::MODE_PUSH_PULL: begin
                    active = {DATA_IN && run && pp_next_b,
                              DATA_IN && run && !pp_next_b,
                              DATA_IN && run && pp_next_b,
                              DATA_IN && run && !pp_next_b};
                    force_ovr = {4{shut}};
                end
                default: begin
                    active    = 4'h0;
                    force_ovr = 4'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Output stages
    // ------------------------------------------------------------
    for (genvar i = 0; i < cwm_pkg::NOUT; i++) begin : g_out
        cwm_outstage u_stage (
            .CLOCK     (CLOCK),
            .RST       (RST),
            .active    (active[i]),
            .force_ovr (force_ovr[i]),
            .ovr_level (ovr[i]),
            .polarity  (polarity_per_output[i]),
            .pin       (out_pins[i])
        );
    end

    assign OUT_A = out_pins[0];
    assign OUT_B = out_pins[1];
    assign OUT_C = out_pins[2];
    assign OUT_D = out_pins[3];

    // ------------------------------------------------------------
    // Register read-back
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RDATA <= cwm_pkg::RD_ZERO;
        end else if (RD) begin
            case (ADDR)
                cwm_pkg::OFS_CONTROL_0: RDATA <= {enable, 4'h0, mode};
                cwm_pkg::OFS_CONTROL_1: RDATA <= {out_pins,
                                                  polarity_per_output};
                cwm_pkg::OFS_STEER:     RDATA <= {ovr, steer};
                cwm_pkg::OFS_DB_RISE:   RDATA <= {2'b00, db_rise};
                cwm_pkg::OFS_DB_FALL:   RDATA <= {2'b00, db_fall};
                cwm_pkg::OFS_DB_EN:     RDATA <= {6'h00, db_fall_en,
                                                  db_rise_en};
                cwm_pkg::OFS_SHUTDOWN:  RDATA <= {shut, 5'h00,
                                                  auto_restart, pin_src_en};
                default:                RDATA <= cwm_pkg::RD_ZERO;
            endcase
        end else begin
            RDATA <= cwm_pkg::RD_ZERO;
        end
    end

endmodule

// ==== tb/cwm_chk.sv ====
// Port checker of the waveform generator, bound to its top module.
// Assumes register shadows may be rebuilt from the register port.
`timescale 1ns/1ps
module cwm_chk (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RST,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic       RD,
    input wire logic [7:0] RDATA,
    // Waveform
    input wire logic       DATA_IN,
    input wire logic       FAULT_IN,
    input wire logic       OUT_A,
    input wire logic       OUT_B,
    input wire logic       OUT_C,
    input wire logic       OUT_D
);
    // ------------------------------------------------------------
    // Shadows
    // ------------------------------------------------------------
    logic       en;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [7:0] steer;
    logic [1:0] db_en;
    logic       dir;
    logic       dprev;
    logic [3:0] quiet;
    logic [3:0] dstable;
    logic [3:0] outs;
    assign outs = {OUT_A, OUT_B, OUT_C, OUT_D};

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            en <= 1'b0;
            mode <= 3'h0;
            pol <= 4'h0;
            steer <= 8'h00;
            db_en <= 2'b00;
        end else if (WR) begin
            if (ADDR == cwm_pkg::OFS_CONTROL_0) begin
                en <= WDATA[7];
                mode <= WDATA[2:0];
            end
            if (ADDR == cwm_pkg::OFS_CONTROL_1)
                pol <= WDATA[3:0];
            if (ADDR == cwm_pkg::OFS_STEER)
                steer <= WDATA;
            if (ADDR == cwm_pkg::OFS_DB_EN)
                db_en <= WDATA[1:0];
        end
    end

    // Settling counters keep the checks off the transition cycles
    always_ff @(posedge CLOCK) begin
        dprev <= DATA_IN;
        if (RST || WR)
            quiet <= 4'h0;
        else if (quiet != 4'hF)
            quiet <= quiet + 4'h1;
        if (RST || DATA_IN != dprev)
            dstable <= 4'h0;
        else if (dstable != 4'hF)
            dstable <= dstable + 4'h1;
        if (RST)
            dir <= 1'b0;
        else if (!en || (DATA_IN && !dprev))
            dir <= mode[0];
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    sequence s_calm;
        quiet >= 4'h3 && dstable >= 4'h3 && DATA_IN == dprev;
    endsequence

    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data not zero outside read");
    a_unmapped_read: assert property ($past(RD) && $past(ADDR) > 4'h6
        |-> RDATA == 8'h00) else $error("unmapped read not zero");
    a_steer_read: assert property ($past(RD)
        && $past(ADDR) == cwm_pkg::OFS_STEER |-> RDATA == steer)
        else $error("steer readback wrong");
    a_reset_outs: assert property (disable iff (1'b0) RST |=> outs == 4'hF)
        else $error("outputs not high after reset");
    a_disabled_idle: assert property (!en && quiet >= 4'h3
        && (pol == 4'hF || pol == 4'h0) |-> outs == {4{~pol[0]}})
        else $error("disabled outputs not inactive");
    a_undef_idle: assert property (en && mode[2:1] == 2'b11
        && pol == 4'hF && quiet >= 4'h3 |-> outs == 4'h0)
        else $error("undefined mode drives outputs");
    a_hb_overlap: assert property (en && mode == 3'h4
        && pol == 4'hF && quiet != 4'h0 |-> !(OUT_A && OUT_B))
        else $error("half-bridge outputs overlap");
    a_hb_follow: assert property ((en && mode == 3'h4
        && pol == 4'hF && db_en == 2'b00) ##0 s_calm
        |-> outs == {DATA_IN, !DATA_IN, DATA_IN, !DATA_IN})
        else $error("half-bridge outputs wrong");
    a_pp_alternate: assert property ((en && mode == 3'h5
        && pol == 4'hF) ##0 s_calm |-> OUT_C == OUT_A
        && OUT_D == OUT_B && (OUT_A ^ OUT_B) == DATA_IN)
        else $error("push-pull outputs wrong");
    a_fb_static: assert property ((en && pol == 4'hF
        && mode[2:1] == cwm_pkg::FB_MODE_HI && !db_en[0]) ##0 s_calm
        |-> outs == (dir ? {1'b0, DATA_IN, 1'b1, 1'b0}
                         : {1'b1, 1'b0, 1'b0, DATA_IN}))
        else $error("full-bridge outputs wrong");
    a_steer_override: assert property (en && mode == 3'h0
        && steer[3:0] == 4'h0 && quiet >= 4'h3
        && (steer[7:4] == 4'hF || steer[7:4] == 4'h0)
        |-> outs == {4{steer[4]}}) else $error("override level wrong");
endmodule

bind cwm_top cwm_chk u_chk (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
    .RD(RD), .RDATA(RDATA), .DATA_IN(DATA_IN), .FAULT_IN(FAULT_IN),
    .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_C(OUT_C), .OUT_D(OUT_D)
);

// ==== tb/cwm_bridge_model.sv ====
// Model of one bridge leg driven by a high-side and a low-side gate.
// Assumes active-high drivers: a gate at 1 turns its switch on.
`timescale 1ns/1ps
module cwm_bridge_model (
    // Clock and reset
    input wire logic       CLOCK,
    input wire logic       RST,
    // Gates
    input wire logic       gate_hi,
    input wire logic       gate_lo,
    // Observations
    output logic           shoot,
    output logic     [7:0] gap
);
    logic [7:0] off_run;

    // Both switches on shorts the supply, so the event latches
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            shoot <= 1'b0;
            gap <= 8'h00;
            off_run <= 8'h00;
        end else begin
            if (gate_hi && gate_lo)
                shoot <= 1'b1;
            if (!gate_hi && !gate_lo)
                off_run <= off_run + 8'h01;
            else if (off_run != 8'h00) begin
                gap <= off_run;
                off_run <= 8'h00;
            end
        end
    end
endmodule

// ==== tb/complementary_waveform_modes_bench.sv ====
// Self-checking bench of the waveform generator over its register port.
// Assumes the checker is bound to the top module from its own file.
`timescale 1ns/1ps
module complementary_waveform_modes_bench;
    logic       CLOCK;
    logic       RST;
    logic [3:0] ADDR;
    logic [7:0] WDATA;
    logic       WR;
    logic       RD;
    logic [7:0] RDATA;
    logic       DATA_IN;
    logic       FAULT_IN;
    logic       OUT_A;
    logic       OUT_B;
    logic       OUT_C;
    logic       OUT_D;
    logic [3:0] outs;
    logic       shoot;
    logic [7:0] gap;
    logic       leg_rst;
    logic [2:0] cur;
    int         n_errors;
    int         num_checks;
    int         cycles;
    assign outs = {OUT_A, OUT_B, OUT_C, OUT_D};

    cwm_top dut (
        .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .DATA_IN(DATA_IN), .FAULT_IN(FAULT_IN),
        .OUT_A(OUT_A), .OUT_B(OUT_B), .OUT_C(OUT_C), .OUT_D(OUT_D)
    );
    cwm_bridge_model u_leg (
        .CLOCK(CLOCK), .RST(leg_rst), .gate_hi(OUT_A), .gate_lo(OUT_B),
        .shoot(shoot), .gap(gap)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLOCK);
        WR <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge CLOCK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLOCK);
        RD <= 1'b0;
        #1;
        chk(RDATA, e);
    endtask
    task automatic dat(input logic v);
        @(posedge CLOCK);
        DATA_IN <= v;
    endtask
    task automatic flt(input logic v);
        @(posedge CLOCK);
        FAULT_IN <= v;
    endtask
    // Waits a bounded time for a pin pattern, then compares it
    task automatic exp_out(input logic [3:0] e);
        int k;
        k = 0;
        do begin
            @(posedge CLOCK);
            #1;
            k++;
        end while (outs !== e && k < 20);
        chk({4'h0, outs}, {4'h0, e});
    endtask
    task automatic hold(input logic [3:0] e, input int n);
        repeat (n) begin
            @(posedge CLOCK);
            #1;
            chk({4'h0, outs}, {4'h0, e});
        end
    endtask
    // This task changes mode only with the generator disabled
    task automatic enter(input logic [2:0] m);
        wr(cwm_pkg::OFS_CONTROL_0, {5'h00, cur});
        wr(cwm_pkg::OFS_CONTROL_0, {5'h00, m});
        wr(cwm_pkg::OFS_CONTROL_0, {5'h10, m});
        cur = m;
    endtask
    task automatic pp(input logic [3:0] e);
        dat(1'b1);
        exp_out(e);
        hold(e, 2);
        dat(1'b0);
        exp_out(4'h0);
    endtask

    // ------------------------------------------------------------
    // Clock, timeout and sequence
    // ------------------------------------------------------------
    initial begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end

    initial begin
        {WR, RD, DATA_IN, FAULT_IN, ADDR, WDATA} <= '0;
        {RST, leg_rst} <= 2'b11;
        cur = 3'h0;
        repeat (10) @(posedge CLOCK);
        RST <= 1'b0;
        hold(4'hF, 3);
        for (logic [3:0] i = 4'h0; i < 4'h7; i++)
            rd(i, (i == 4'h1) ? 8'hF0 : 8'h00);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        wr(cwm_pkg::OFS_DB_RISE, 8'hFF);
        rd(cwm_pkg::OFS_DB_RISE, 8'h3F);
        wr(cwm_pkg::OFS_STEER, 8'hF0);
        wr(cwm_pkg::OFS_CONTROL_1, 8'h0F);
        exp_out(4'h0);
        // Half-bridge with mirrored C and D, steering ignored
        enter(3'h4);
        exp_out(4'h5);
        dat(1'b1);
        exp_out(4'hA);
        wr(cwm_pkg::OFS_CONTROL_1, 8'h06);
        exp_out(4'h3);
        dat(1'b0);
        exp_out(4'hC);
        wr(cwm_pkg::OFS_CONTROL_1, 8'h0F);
        wr(cwm_pkg::OFS_DB_RISE, 8'h05);
        wr(cwm_pkg::OFS_DB_EN, 8'h01);
        leg_rst <= 1'b0;
        dat(1'b1);
        repeat (5) @(posedge CLOCK);
        #1;
        chk({7'h00, OUT_A}, 8'h00);
        exp_out(4'hA);
        hold(4'hA, 1);
        chk({7'h00, gap == 8'h05}, 8'h01);
        wr(cwm_pkg::OFS_DB_FALL, 8'h03);
        wr(cwm_pkg::OFS_DB_EN, 8'h03);
        dat(1'b0);
        exp_out(4'h5);
        hold(4'h5, 1);
        chk({7'h00, gap == 8'h03}, 8'h01);
        chk({7'h00, shoot}, 8'h00);
        wr(cwm_pkg::OFS_DB_EN, 8'h00);
        // Push-pull alternation and sequencer reset
        enter(3'h5);
        pp(4'hA);
        pp(4'h5);
        pp(4'hA);
        enter(3'h5);
        pp(4'hA);
        // Full-bridge with direction toggle while enabled
        enter(3'h2);
        exp_out(4'h8);
        dat(1'b1);
        exp_out(4'h9);
        wr(cwm_pkg::OFS_CONTROL_0, 8'h83);
        hold(4'h9, 4);
        dat(1'b0);
        exp_out(4'h8);
        dat(1'b1);
        exp_out(4'h6);
        dat(1'b0);
        exp_out(4'h2);
        cur = 3'h3;
        // Undefined codes
        for (logic [2:0] m = 3'h6; m != 3'h0; m++) begin
            enter(m);
            dat(1'b1);
            hold(4'h0, 4);
            dat(1'b0);
        end
        // Asynchronous and synchronous steering
        enter(3'h0);
        exp_out(4'hF);
        wr(cwm_pkg::OFS_STEER, 8'h0F);
        exp_out(4'h0);
        dat(1'b1);
        exp_out(4'hF);
        wr(cwm_pkg::OFS_STEER, 8'h00);
        hold(4'h0, 3);
        wr(cwm_pkg::OFS_CONTROL_1, 8'h00);
        hold(4'h0, 3);
        wr(cwm_pkg::OFS_CONTROL_1, 8'h0F);
        enter(3'h1);
        wr(cwm_pkg::OFS_STEER, 8'h0F);
        hold(4'h0, 4);
        dat(1'b0);
        dat(1'b1);
        exp_out(4'hF);
        // Shutdown by pin, by software and with auto-restart
        enter(3'h4);
        wr(cwm_pkg::OFS_STEER, 8'h00);
        wr(cwm_pkg::OFS_CONTROL_1, 8'h00);
        exp_out(4'h5);
        wr(cwm_pkg::OFS_SHUTDOWN, 8'h01);
        flt(1'b1);
        exp_out(4'h0);
        rd(cwm_pkg::OFS_SHUTDOWN, 8'h81);
        flt(1'b0);
        hold(4'h0, 3);
        wr(cwm_pkg::OFS_SHUTDOWN, 8'h01);
        exp_out(4'h5);
        wr(cwm_pkg::OFS_SHUTDOWN, 8'h81);
        exp_out(4'h0);
        wr(cwm_pkg::OFS_SHUTDOWN, 8'h03);
        exp_out(4'h5);
        flt(1'b1);
        exp_out(4'h0);
        flt(1'b0);
        exp_out(4'h5);
        give_verdict();
    end
endmodule
